// ==== rtl/gpt_pkg.sv ====
/*
 * Constants, register map and config layout of the 32-bit timer.
 * Assumes a 32-bit byte-addressed register port on the core clock.
 */
// Behaviour
// - Counter is 32 bits; config bit 8 set counts up, clear counts down.
// - Config bit 7 enables counting; clear after reset, so timer starts stopped.
// - Config bit 6 selects periodic when set, free-running when clear.
// - Prescale bits 3:0 divide by 1, 16, 256, 32768 for 0000/0100/1000/1111.
// - Bits 11:9 pick core clock, 32.768 kHz, undivided clock or pin edges.
// - Bits 5:4 pick binary, time up to 23 hours, or up to 255 hours.
// - Config bit 17 enables capture of the selected event.
// - Bits 16:12 choose capture event 0 to 25, source number minus two.
// - Capture copies the counter on the first assertion of the chosen source.
// - A read-only value register always shows the present counter.
// - A read/write load register holds the reload value.
// - Timer produces a trigger that starts an ADC conversion.
// - Periodic mode restarts from the load value at zero or full scale.
// - Free-running wraps zero to maximum going down, full to minimum going up.
// - Interrupt raised each time count reaches zero down or full scale up.
// - Writing any value to the clear register clears the pending timeout interrupt, not the capture flag.
package gpt_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [31:0] GPT_OFS_RELOAD = 32'hffff0320;
	localparam logic [31:0] GPT_OFS_COUNT = 32'hffff0324;
	localparam logic [31:0] GPT_OFS_CONFIG = 32'hffff0328;
	localparam logic [31:0] GPT_OFS_CLEAR = 32'hffff032c;
	localparam logic [31:0] GPT_OFS_CAPTURE = 32'hffff0330;
	localparam logic [31:0] GPT_OFS_STATUS = 32'hffff0334;
	localparam logic [31:0] GPT_OFS_MASK = 32'hffff0338;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] GPT_RST_RELOAD = 32'h00000000;
	localparam logic [31:0] GPT_RST_COUNT = 32'h0fffffff;
	localparam logic [17:0] GPT_RST_CONFIG = 18'h00000;
	localparam logic [31:0] GPT_RST_CAPTURE = 32'h00000000;
	localparam logic [1:0] GPT_RST_IRQ = 2'h0;
	// Status bit positions
	localparam int GPT_ST_TIMEOUT = 0;
	localparam int GPT_ST_CAPTURE = 1;
	// ****************************************
	// Config field codes
	// ****************************************
	localparam logic [3:0] GPT_PRE_DIV16 = 4'h4;
	localparam logic [3:0] GPT_PRE_DIV256 = 4'h8;
	localparam logic [3:0] GPT_PRE_DIV32K = 4'hf;
	localparam logic [14:0] GPT_DMAX_1 = 15'h0000;
	localparam logic [14:0] GPT_DMAX_16 = 15'h000f;
	localparam logic [14:0] GPT_DMAX_256 = 15'h00ff;
	localparam logic [14:0] GPT_DMAX_32K = 15'h7fff;
	localparam logic [1:0] GPT_FMT_H23 = 2'h2;
	localparam logic [1:0] GPT_FMT_H255 = 2'h3;
	localparam logic [7:0] GPT_HMAX_23 = 8'h17;
	localparam logic [7:0] GPT_HMAX_255 = 8'hff;
	localparam logic [7:0] GPT_MAX_MS = 8'h3b;
	localparam logic [7:0] GPT_MAX_HUND = 8'h63;
	localparam logic [4:0] GPT_EVT_MAX = 5'h19;
	localparam int GPT_NUM_EVT = 26;

	typedef enum logic [2:0] {
		GPT_SRC_CORE = 3'b000,
		GPT_SRC_SLOW = 3'b001,
		GPT_SRC_UNDIV = 3'b010,
		GPT_SRC_PIN = 3'b011
	} gpt_src_t;

	// Config register layout, bits 17:0
	typedef struct packed {
		logic cap_en;
		logic [4:0] evt_sel;
		logic [2:0] src_sel;
		logic count_up;
		logic enable;
		logic periodic;
		logic [1:0] fmt;
		logic [3:0] prescale;
	} gpt_cfg_t;
endpackage

// ==== rtl/gpt_timer.sv ====
/*
 * General-purpose 32-bit up/down timer with prescaler, time format,
 * event capture, ADC trigger and a sticky interrupt register.
 * Assumes the register port and event sources run on clk; the slow,
 * undivided and pin count sources are asynchronous and synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
module gpt_timer
	import gpt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Count sources, asynchronous
	input wire logic slow_clk_in,
	input wire logic undivided_system_clock,
	input wire logic external_count_pin,
	// Interrupt sources for capture, offset by two
	input wire logic [GPT_NUM_EVT-1:0] irq_src,
	// Outputs
	output logic irq,
	output logic adc_trigger
);
	// ****************************************
	// Helpers
	// ****************************************
	// Prescaler terminal count per code
	function automatic logic [14:0] div_max(input logic [3:0] code);
		case (code)
			GPT_PRE_DIV16: div_max = GPT_DMAX_16;
			GPT_PRE_DIV256: div_max = GPT_DMAX_256;
			GPT_PRE_DIV32K: div_max = GPT_DMAX_32K;
			default: div_max = GPT_DMAX_1;
		endcase
	endfunction

	// One step of the time-format counter, fields wrap at natural limits
	function automatic logic [31:0] tm_step(input logic [31:0] v, input logic up,
		input logic [7:0] hmax);
		logic [7:0] h;
		logic [7:0] m;
		logic [7:0] s;
		logic [7:0] c;
		h = v[31:24];
		m = v[23:16];
		s = v[15:8];
		c = v[7:0];
		if (up) begin
			if (c < GPT_MAX_HUND) c = c + 8'h01;
			else begin
				c = 8'h00;
				if (s < GPT_MAX_MS) s = s + 8'h01;
				else begin
					s = 8'h00;
					if (m < GPT_MAX_MS) m = m + 8'h01;
					else begin
						m = 8'h00;
						h = (h < hmax) ? h + 8'h01 : 8'h00;
					end
				end
			end
		end else begin
			if (c != 8'h00) c = c - 8'h01;
			else begin
				c = GPT_MAX_HUND;
				if (s != 8'h00) s = s - 8'h01;
				else begin
					s = GPT_MAX_MS;
					if (m != 8'h00) m = m - 8'h01;
					else begin
						m = GPT_MAX_MS;
						h = (h != 8'h00) ? h - 8'h01 : hmax;
					end
				end
			end
		end
		tm_step = {h, m, s, c};
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	gpt_cfg_t cfg_r;
	logic [31:0] reload_r;
	logic [31:0] count_r;
	logic [31:0] count_nxt;
	logic [31:0] capture_r;
	logic [1:0] status_r;
	logic [1:0] status_nxt;
	logic [1:0] mask_r;
	logic [14:0] pre_r;
	logic [14:0] pre_nxt;
	logic [2:0] slow_s_r;
	logic [2:0] undiv_s_r;
	logic [2:0] pin_s_r;
	logic src_prev_r;
	logic adc_r;

	// ****************************************
	// Register decode
	// ****************************************
	wire logic wr_reload = wr && (addr == GPT_OFS_RELOAD);
	wire logic wr_config = wr && (addr == GPT_OFS_CONFIG);
	wire logic wr_clear = wr && (addr == GPT_OFS_CLEAR);
	wire logic wr_capture = wr && (addr == GPT_OFS_CAPTURE);
	wire logic wr_status = wr && (addr == GPT_OFS_STATUS);
	wire logic wr_mask = wr && (addr == GPT_OFS_MASK);

	// ****************************************
	// Source selection and prescaler
	// ****************************************
	// Edges taken from the second and third stage only
	wire logic slow_edge = slow_s_r[1] & ~slow_s_r[2];
	wire logic undiv_edge = undiv_s_r[1] & ~undiv_s_r[2];
	wire logic pin_edge = pin_s_r[1] & ~pin_s_r[2];
	wire logic src_tick = (cfg_r.src_sel == GPT_SRC_CORE) ? 1'b1 :
		(cfg_r.src_sel == GPT_SRC_SLOW) ? slow_edge :
		(cfg_r.src_sel == GPT_SRC_UNDIV) ? undiv_edge :
		(cfg_r.src_sel == GPT_SRC_PIN) ? pin_edge : 1'b0;
	wire logic [14:0] pre_max = div_max(cfg_r.prescale);
	wire logic pre_wrap = (pre_r >= pre_max);
	wire logic cnt_tick = cfg_r.enable && src_tick && pre_wrap;

	// Prescaler held at zero while stopped so a restart is a full period
	always_comb begin
		pre_nxt = pre_r;
		if (!cfg_r.enable) pre_nxt = 15'h0000;
		else if (src_tick) pre_nxt = pre_wrap ? 15'h0000 : pre_r + 15'h0001;
	end

	// ****************************************
	// Counter
	// ****************************************
	// Reserved format code falls back to binary
	wire logic is_time = cfg_r.fmt[1];
	wire logic [7:0] hmax = (cfg_r.fmt == GPT_FMT_H255) ? GPT_HMAX_255 : GPT_HMAX_23;
	wire logic [31:0] full_val = is_time ? {hmax, GPT_MAX_MS, GPT_MAX_MS, GPT_MAX_HUND}
		: 32'hffffffff;
	wire logic [31:0] term_val = cfg_r.count_up ? full_val : 32'h00000000;
	wire logic [31:0] bin_step = cfg_r.count_up ? count_r + 32'h00000001
		: count_r - 32'h00000001;
	// Natural wrap gives free-running behaviour in both formats
	wire logic [31:0] step_val = is_time ? tm_step(count_r, cfg_r.count_up, hmax)
		: bin_step;
	wire logic at_term = (count_r == term_val);
	wire logic hit_term = cnt_tick && (step_val == term_val);

	// Reload on a load write or on leaving terminal in periodic mode
	always_comb begin
		count_nxt = count_r;
		if (wr_reload) count_nxt = wdata;
		else if (cnt_tick && cfg_r.periodic && at_term) count_nxt = reload_r;
		else if (cnt_tick) count_nxt = step_val;
	end

	// ****************************************
	// Capture
	// ****************************************
	// Source assumed synchronous; edge marks its first assertion
	wire logic evt_ok = (cfg_r.evt_sel <= GPT_EVT_MAX);
	wire logic src_lvl = evt_ok && irq_src[cfg_r.evt_sel];
	wire logic cap_fire = cfg_r.cap_en && src_lvl && !src_prev_r;

	// ****************************************
	// Interrupt status
	// ****************************************
	// New events win over a clear in the same cycle
	always_comb begin
		status_nxt = status_r;
		if (wr_status) status_nxt = status_r & ~wdata[1:0];
		if (wr_clear) status_nxt[GPT_ST_TIMEOUT] = 1'b0;
		if (hit_term) status_nxt[GPT_ST_TIMEOUT] = 1'b1;
		if (cap_fire) status_nxt[GPT_ST_CAPTURE] = 1'b1;
	end

	assign irq = |(status_r & mask_r);
	assign adc_trigger = adc_r;

	// ****************************************
	// Read mux
	// ****************************************
	wire logic [31:0] rd_val =
		(addr == GPT_OFS_RELOAD) ? reload_r :
		(addr == GPT_OFS_COUNT) ? count_r :
		(addr == GPT_OFS_CONFIG) ? {14'h0000, cfg_r} :
		(addr == GPT_OFS_CAPTURE) ? capture_r :
		(addr == GPT_OFS_STATUS) ? {30'h00000000, status_r} :
		(addr == GPT_OFS_MASK) ? {30'h00000000, mask_r} : 32'h00000000;

	// ****************************************
	// Sequential logic
	// ****************************************
	// Synchronisers for the asynchronous count sources
	always_ff @(posedge clk) begin
		if (!nrst) begin
			slow_s_r <= 3'h0;
			undiv_s_r <= 3'h0;
			pin_s_r <= 3'h0;
		end else begin
			slow_s_r <= {slow_s_r[1:0], slow_clk_in};
			undiv_s_r <= {undiv_s_r[1:0], undivided_system_clock};
			pin_s_r <= {pin_s_r[1:0], external_count_pin};
		end
	end

	// Software registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_r <= GPT_RST_CONFIG;
			reload_r <= GPT_RST_RELOAD;
			mask_r <= GPT_RST_IRQ;
		end else begin
			if (wr_config) cfg_r <= wdata[17:0];
			if (wr_reload) reload_r <= wdata;
			if (wr_mask) mask_r <= wdata[1:0];
		end
	end

	// Counter, prescaler and capture
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_r <= GPT_RST_COUNT;
			pre_r <= 15'h0000;
			capture_r <= GPT_RST_CAPTURE;
			src_prev_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			pre_r <= pre_nxt;
			src_prev_r <= src_lvl;
			if (cap_fire) capture_r <= count_r;
			else if (wr_capture) capture_r <= wdata;
		end
	end

	// Status, trigger and read data
	always_ff @(posedge clk) begin
		if (!nrst) begin
			status_r <= GPT_RST_IRQ;
			adc_r <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			status_r <= status_nxt;
			adc_r <= hit_term;
			rdata <= rd ? rd_val : 32'h00000000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence seq_tick_term;
		cnt_tick && at_term && !wr_reload;
	endsequence

	sequence seq_tick_mid;
		cnt_tick && !at_term && !wr_reload;
	endsequence

	a_bin_down: assert property (seq_tick_mid and (!is_time && !cfg_r.count_up)
		|=> count_r == $past(count_r) - 32'h00000001)
		else $error("down count step wrong");
	a_stop_hold: assert property (!cfg_r.enable && !wr_reload |=> $stable(count_r))
		else $error("stopped counter moved");
	a_period_reload: assert property (seq_tick_term and cfg_r.periodic
		|=> count_r == $past(reload_r))
		else $error("periodic reload missed");
	a_free_wrap: assert property (seq_tick_term and (!cfg_r.periodic && !is_time
		&& !cfg_r.count_up) |=> count_r == 32'hffffffff)
		else $error("free-running wrap wrong");
	a_pre_bound: assert property (cfg_r.enable |-> pre_r <= pre_max)
		else $error("prescaler beyond divide");
	a_odd_prescale: assert property (cfg_r.enable && src_tick && pre_max == GPT_DMAX_1
		|-> cnt_tick)
		else $error("divide by one missed tick");
	a_cap_copy: assert property (cap_fire |=> capture_r == $past(count_r))
		else $error("capture lost count");
	a_cap_off: assert property (!cfg_r.cap_en && !wr_capture |=> $stable(capture_r))
		else $error("capture while disabled");
	a_irq_set: assert property (hit_term |=> status_r[GPT_ST_TIMEOUT] && adc_trigger)
		else $error("timeout not flagged");
	a_irq_clear: assert property (wr_clear && !hit_term |=> !status_r[GPT_ST_TIMEOUT])
		else $error("clear did not clear");
	// Only counting steps are judged; software may load any pattern
	a_time_hund: assert property (seq_tick_mid and (is_time
		&& count_r[7:0] <= GPT_MAX_HUND) |=> count_r[7:0] <= GPT_MAX_HUND)
		else $error("hundredths out of range");
	// Capture event must also leave its sticky flag behind
	a_cap_flag: assert property (cap_fire |=> status_r[GPT_ST_CAPTURE])
		else $error("capture flag not set");
	// Stale read data must never leak past its one cycle
	a_rd_idle: assert property (!rd |=> rdata == 32'h00000000)
		else $error("read data not cleared");
endmodule // gpt_timer
`default_nettype wire

// ==== tb/gpt_timer_tb_top.sv ====
/*
 * Self-checking bench of the 32-bit timer: registers, counting, sources,
 * time format, interrupt, ADC trigger and event capture.
 * Assumes gpt_pkg and gpt_timer are compiled first; 50 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module gpt_timer_tb_top
	import gpt_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic slow = 1'b0;
	logic undiv = 1'b0;
	logic pin = 1'b0;
	logic [GPT_NUM_EVT-1:0] irq_src = '0;
	logic irq;
	logic adc_trigger;
	int error_cnt = 0;
	int samples_checked = 0;
	logic [31:0] adc_cnt = 32'h0;
	logic [31:0] v, r, a0;
	int k;
	int divs[5] = '{1, 16, 256, 32768, 1};
	int spans[5] = '{40, 320, 1024, 200, 40};
	logic [3:0] codes[5] = '{4'h0, 4'h4, 4'h8, 4'hf, 4'h2};
	int edges[3] = '{5, 7, 9};

	gpt_timer uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .slow_clk_in(slow), .undivided_system_clock(undiv),
		.external_count_pin(pin), .irq_src(irq_src), .irq(irq), .adc_trigger(adc_trigger));

	// Half period of 10 ns gives 50 MHz
	always #10 clk = ~clk;
	// Trigger pulses counted so runs can be compared by difference
	always @(posedge clk) begin
		if (adc_trigger === 1'b1) adc_cnt <= adc_cnt + 32'h1;
	end

	// ****************************************
	// Bus tasks and comparison
	// ****************************************
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data only stand the cycle after the strobe, so sample at that negedge
	task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
		logic [31:0] d;
		samples_checked++;
		d = (got > exp) ? got - exp : exp - got;
		if ((^got === 1'bx) || (d > tol)) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] tol);
		logic [31:0] d;
		rd_reg(a, d);
		chk(d, exp, tol);
	endtask
	// Count left after m core cycles at a given division, counting down
	function automatic logic [31:0] after_down(logic [31:0] s, int m, int div);
		return s - 32'(m / div);
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog: tests need well under 20000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		void'($urandom(57378));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd_chk(GPT_OFS_RELOAD, GPT_RST_RELOAD, 0);
		rd_chk(GPT_OFS_COUNT, GPT_RST_COUNT, 0);
		rd_chk(GPT_OFS_CONFIG, 32'h0, 0);
		rd_chk(GPT_OFS_CAPTURE, GPT_RST_CAPTURE, 0);
		rd_chk(GPT_OFS_STATUS, 32'h0, 0);
		$display("test reset done");
		// Read/write places, read-only count, unmapped hole
		r = $urandom;
		wr_reg(GPT_OFS_RELOAD, r);
		rd_chk(GPT_OFS_RELOAD, r, 0);
		wr_reg(GPT_OFS_COUNT, ~r);
		rd_chk(GPT_OFS_COUNT, r, 0);
		v = $urandom & 32'h0003ff7f;
		wr_reg(GPT_OFS_CONFIG, v);
		rd_chk(GPT_OFS_CONFIG, v, 0);
		wr_reg(GPT_OFS_CONFIG, 32'h0);
		rd_chk(32'hffff033c, 32'h0, 0);
		$display("test registers done");
		// Prescale codes, listed and unlisted
		for (int i = 0; i < 5; i++) begin
			r = $urandom | 32'h00100000;
			wr_reg(GPT_OFS_RELOAD, r);
			wr_reg(GPT_OFS_CONFIG, {24'h0, 4'h8, codes[i]});
			repeat (spans[i]) @(posedge clk);
			wr_reg(GPT_OFS_CONFIG, 32'h0);
			rd_chk(GPT_OFS_COUNT, after_down(r, spans[i] + 1, divs[i]), 3);
		end
		$display("test prescale done");
		// Sources: each input gets a different edge count, code 100 never ticks
		for (int s = 1; s < 5; s++) begin
			wr_reg(GPT_OFS_RELOAD, 32'h1000);
			wr_reg(GPT_OFS_CONFIG, 32'h80 | (s << 9));
			for (int e = 0; e < 9; e++) begin
				slow <= (e < edges[0]);
				undiv <= (e < edges[1]);
				pin <= 1'b1;
				repeat (4) @(posedge clk);
				{slow, undiv, pin} <= 3'b000;
				repeat (4) @(posedge clk);
			end
			repeat (4) @(posedge clk);
			wr_reg(GPT_OFS_CONFIG, 32'h0);
			rd_chk(GPT_OFS_COUNT, 32'h1000 - ((s < 4) ? edges[s - 1] : 0), 0);
		end
		$display("test sources done");
		// Periodic down from 3 with interrupt unmasked
		wr_reg(GPT_OFS_MASK, 32'h1);
		wr_reg(GPT_OFS_RELOAD, 32'h3);
		a0 = adc_cnt;
		wr_reg(GPT_OFS_CONFIG, 32'hc0);
		repeat (40) @(posedge clk);
		rd_chk(GPT_OFS_COUNT, 32'h2, 2);
		wr_reg(GPT_OFS_CONFIG, 32'h0);
		@(negedge clk);
		chk(adc_cnt - a0, 32'd11, 2);
		chk({31'h0, irq}, 32'h1, 0);
		wr_reg(GPT_OFS_CLEAR, $urandom);
		rd_chk(GPT_OFS_STATUS, 32'h0, 0);
		chk({31'h0, irq}, 32'h0, 0);
		// Free-running wraps both ways, W1C and mask
		wr_reg(GPT_OFS_RELOAD, 32'h2);
		wr_reg(GPT_OFS_CONFIG, 32'h80);
		repeat (10) @(posedge clk);
		wr_reg(GPT_OFS_CONFIG, 32'h0);
		rd_chk(GPT_OFS_COUNT, 32'hfffffff7, 3);
		wr_reg(GPT_OFS_MASK, 32'h0);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0, 0);
		wr_reg(GPT_OFS_STATUS, 32'h1);
		rd_chk(GPT_OFS_STATUS, 32'h0, 0);
		wr_reg(GPT_OFS_RELOAD, 32'hfffffffd);
		wr_reg(GPT_OFS_CONFIG, 32'h180);
		repeat (10) @(posedge clk);
		wr_reg(GPT_OFS_CONFIG, 32'h0);
		rd_chk(GPT_OFS_COUNT, 32'h8, 4);
		wr_reg(GPT_OFS_RELOAD, 32'hfffffffc);
		wr_reg(GPT_OFS_CONFIG, 32'h1c0);
		repeat (10) @(posedge clk);
		wr_reg(GPT_OFS_CONFIG, 32'h0);
		rd_chk(GPT_OFS_COUNT, 32'hfffffffd, 2);
		$display("test modes done");
		// Time format, 23-hour wrap counting up
		wr_reg(GPT_OFS_STATUS, 32'h3);
		wr_reg(GPT_OFS_RELOAD, 32'h173b3b62);
		wr_reg(GPT_OFS_CONFIG, 32'h1a0);
		repeat (8) @(posedge clk);
		wr_reg(GPT_OFS_CONFIG, 32'h0);
		rd_chk(GPT_OFS_COUNT, 32'h7, 5);
		rd_chk(GPT_OFS_STATUS, 32'h1, 0);
		$display("test time format done");
		// Capture on a random event, then with capture off
		wr_reg(GPT_OFS_STATUS, 32'h3);
		r = $urandom;
		k = $urandom_range(25);
		wr_reg(GPT_OFS_RELOAD, r);
		wr_reg(GPT_OFS_CONFIG, 32'h20000 | (k << 12));
		irq_src[(k + 1) % 26] <= 1'b1;
		@(posedge clk);
		irq_src <= '0;
		rd_chk(GPT_OFS_STATUS, 32'h0, 0);
		@(posedge clk);
		irq_src[k] <= 1'b1;
		@(posedge clk);
		rd_chk(GPT_OFS_CAPTURE, r, 0);
		rd_chk(GPT_OFS_STATUS, 32'h2, 0);
		@(posedge clk);
		irq_src <= '0;
		wr_reg(GPT_OFS_STATUS, 32'h2);
		wr_reg(GPT_OFS_RELOAD, ~r);
		wr_reg(GPT_OFS_CONFIG, k << 12);
		irq_src[k] <= 1'b1;
		@(posedge clk);
		irq_src <= '0;
		rd_chk(GPT_OFS_CAPTURE, r, 0);
		rd_chk(GPT_OFS_STATUS, 32'h0, 0);
		$display("test capture done");
		conclude();
	end
endmodule // gpt_timer_tb_top
`default_nettype wire
